// ==== logic/channel_fault_defines.svh ====
`ifndef CHANNEL_FAULT_DEFINES_SVH
`define CHANNEL_FAULT_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL          12'h000
`define ADDR_CLEAR         12'h004
`define ADDR_STATUS        12'h008
`define ADDR_CFG2          12'h00c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_EN_LSB        0
`define CTRL_PAIR_LSB      8
`define CTRL_OCSEL_BIT     12
`define STATUS_ERR_LSB     0
`define STATUS_UV_BIT      8
`define STATUS_MODE_BIT    9
`define CFG2_WARN_BIT      0
`define CTRL_RESET         13'h0000

// ----------------------------------------------------------------
// timing: figures in ns, counts at the 40 ns system clock
// ----------------------------------------------------------------
`define CLK_NS             40
`define SYNC_NS            1000
`define INRUSH_NS          50000
`define FILTER_NS          4000
`define RESTART_BASE_NS    10000000
`define TWO_SYNC_CYC       ((2 * `SYNC_NS + `CLK_NS - 1) / `CLK_NS)
`define INRUSH_CYC         ((`INRUSH_NS + `CLK_NS - 1) / `CLK_NS)
`define FILTER_CYC         ((`FILTER_NS + `CLK_NS - 1) / `CLK_NS)
`define RESTART_BASE_CYC   (`RESTART_BASE_NS / `CLK_NS)
`define RETRIES_PER_STAGE  8
`define RETRY_SAT          24

`endif

// ==== logic/channel_fault_pkg.sv ====
`default_nettype none

package channel_fault_pkg;
    typedef logic [7:0]  chan_mask_t;
    typedef logic [10:0] cnt_t;
    typedef logic [21:0] rtime_t;
    typedef logic [4:0]  retry_t;
    typedef enum logic [2:0] {SEL_CTRL, SEL_CLEAR, SEL_STATUS, SEL_CFG2, SEL_NONE} reg_sel_t;
endpackage

`default_nettype wire

// ==== logic/input_sync3.sv ====
`timescale 1ns/10ps
`default_nettype none

module input_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,   // system clock
    input  wire logic             rst_b,     // async reset, active low
    input  wire logic [WIDTH-1:0] asyncIn,   // raw level from outside
    output logic      [WIDTH-1:0] syncOut    // filtered level
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    wire  [WIDTH-1:0] agree = ~(stage2_r ^ stage3_r);

    // three stages; a change is taken once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
            syncOut  <= '0;
        end
        else
        begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            syncOut  <= (syncOut & ~agree) | (stage3_r & agree);
        end
    end
endmodule // input_sync3

`default_nettype wire

// ==== logic/channel_fault_latch_protection.sv ====
// Overview of operation
// - four pair bits couple channels 0/2,1/3,4/6,5/7
// - paired trip also switches partner channel off
// - fault detection and flags stay per channel
// - load supply undervoltage sets undervoltage flag
// - flag clears on first status read after recovery
// - initial threshold during inrush, then steady threshold
// - one select bit chooses both threshold values
// - off longer than two sync periods rearms inrush
// - overcurrent past filter time latches off, flags
// - clear bit releases latch, returns to zero
// - overtemperature latches off with same flag, clear
// - temperature warning sets bit, nothing else
// - warning bit clears itself below hysteresis
// - fallback drives channels 2,3 from pins, retries
// - retry interval 10,20,40 ms per eight, then 80
// - input low two sync periods resets restart timer
// - overvoltage band leaves outputs following requests
// - fallback mode ignores register writes
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "channel_fault_defines.svh"

module channel_fault_latch_protection #(
    parameter int RESTART_BASE_CYC = `RESTART_BASE_CYC
) (
    input  wire logic                          clk_sys,        // 25 MHz clock
    input  wire logic                          rst_b,          // async reset, active low
    input  wire logic                          psel,           // apb select
    input  wire logic                          penable,        // apb access phase
    input  wire logic                          pwrite,         // apb direction
    input  wire logic [11:0]                   paddr,          // apb byte address
    input  wire logic [31:0]                   pwdata,         // apb write data
    output logic      [31:0]                   prdata,         // apb read data
    output logic                               pready,         // apb ready
    output logic                               pslverr,        // apb error, unmapped
    input  wire channel_fault_pkg::chan_mask_t overInit,       // current above initial level
    input  wire channel_fault_pkg::chan_mask_t overSteady,     // current above steady level
    input  wire channel_fault_pkg::chan_mask_t overTemp,       // channel sensor hot
    input  wire logic [1:0]                    inPin,          // input pins for ch2, ch3
    input  wire logic                          fallbackMode,   // fail-safe fallback active
    input  wire logic                          supplyUv,       // load supply below lockout
    input  wire logic                          supplyOk,       // load supply above operating
    input  wire logic                          dieHot,         // die above warning trip
    input  wire logic                          dieCool,        // die below hysteresis point
    output channel_fault_pkg::chan_mask_t      chanOn,         // channel gate drive
    output channel_fault_pkg::chan_mask_t      initThrActive,  // initial threshold selected
    output logic                               overcurrentLevelSelect // threshold set select
);
    import channel_fault_pkg::*;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam cnt_t   TWO_SYNC  = cnt_t'(`TWO_SYNC_CYC);
    localparam cnt_t   INRUSH    = cnt_t'(`INRUSH_CYC);
    localparam cnt_t   FILTER_M1 = cnt_t'(`FILTER_CYC - 1);
    localparam rtime_t BASE      = rtime_t'(RESTART_BASE_CYC);
    localparam retry_t RSAT      = retry_t'(`RETRY_SAT);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int partnerOf(input int ch);
        return ch ^ 2;
    endfunction

    function automatic int pairIdx(input int ch);
        return ((ch >> 1) & 2) | (ch & 1);
    endfunction

    function automatic reg_sel_t decode(input logic [11:0] a);
        unique case (a)
            `ADDR_CTRL:   return SEL_CTRL;
            `ADDR_CLEAR:  return SEL_CLEAR;
            `ADDR_STATUS: return SEL_STATUS;
            `ADDR_CFG2:   return SEL_CFG2;
            default:      return SEL_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    chan_mask_t ocInitS;
    chan_mask_t ocSteadyS;
    chan_mask_t otS;
    logic [1:0] inS;
    logic       fbS;
    logic       uvS;
    logic       okS;
    logic       hotS;
    logic       coolS;

    input_sync3 #(.WIDTH(31)) uSync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .asyncIn ({overInit, overSteady, overTemp, inPin, fallbackMode,
                   supplyUv, supplyOk, dieHot, dieCool}),
        .syncOut ({ocInitS, ocSteadyS, otS, inS, fbS, uvS, okS, hotS, coolS})
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [12:0] ctrl_r;
    chan_mask_t  latchClearBit_r;
    chan_mask_t  channelErrorFlag_r;
    logic        loadSupplyUndervoltageFlag_r;
    logic        temperatureWarningBit_r;
    chan_mask_t  latch_r;

    wire reg_sel_t sel      = decode(paddr);
    wire           accFirst = psel & penable & ~pready;
    wire           xferDone = psel & penable & pready;
    wire           wrEn     = xferDone & pwrite & ~fbS;
    wire           rdStatus = xferDone & ~pwrite & (sel == SEL_STATUS);
    wire [31:0]    rdMux    =
        (sel == SEL_CTRL)   ? {19'h0, ctrl_r} :
        (sel == SEL_CLEAR)  ? {24'h0, latchClearBit_r} :
        (sel == SEL_STATUS) ? {22'h0, fbS, loadSupplyUndervoltageFlag_r,
                               channelErrorFlag_r} :
        (sel == SEL_CFG2)   ? {31'h0, temperatureWarningBit_r} : 32'h0;

    // one wait state: data and error are ready with pready
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= accFirst;
            prdata  <= accFirst ? rdMux : prdata;
            pslverr <= accFirst & (sel == SEL_NONE);
        end
    end

    // control register; fallback locks it against writes
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_r <= `CTRL_RESET;
        else if (wrEn && sel == SEL_CTRL)
            ctrl_r <= pwdata[12:0];
    end

    wire chan_mask_t enableBits = ctrl_r[`CTRL_EN_LSB +: 8];
    wire [3:0]       pairBit    = ctrl_r[`CTRL_PAIR_LSB +: 4];
    wire chan_mask_t clrWrite   = (wrEn && sel == SEL_CLEAR) ? pwdata[7:0] : 8'h00;

    // ------------------------------------------------------------
    // per-channel protection
    // ------------------------------------------------------------
    cnt_t       filt_r   [8];
    cnt_t       offCnt_r [8];
    cnt_t       inrush_r [8];
    cnt_t       filtNxt  [8];
    cnt_t       offNxt   [8];
    cnt_t       inrushNxt[8];
    chan_mask_t reqOn;
    chan_mask_t overNow;
    chan_mask_t ownTrip;
    chan_mask_t partnerTrip;
    chan_mask_t latchNxt;
    chan_mask_t errNxt;
    chan_mask_t onNxt;
    chan_mask_t initNxt;
    chan_mask_t relLatch;
    logic [1:0] autoRestart;

    // detection: threshold choice, overcurrent filter, trips
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            // requests keep following inputs in the overvoltage band
            reqOn[i]   = fbS ? ((i == 2 && inS[0]) || (i == 3 && inS[1]))
                             : enableBits[i];
            overNow[i] = initThrActive[i] ? ocInitS[i] : ocSteadyS[i];
            filtNxt[i] = (chanOn[i] && overNow[i]) ? filt_r[i] + 11'h001 : 11'h000;
            ownTrip[i] = (chanOn[i] && overNow[i] && filt_r[i] == FILTER_M1)
                       | otS[i];
        end
        for (int i = 0; i < 8; i++)
        begin
            partnerTrip[i] = pairBit[pairIdx(i)] & ownTrip[partnerOf(i)];
            relLatch[i]    = latchClearBit_r[i]
                           | ((i == 2) && autoRestart[0]) | ((i == 3) && autoRestart[1]);
            // a trip in the clearing cycle wins over the clear
            latchNxt[i]    = ownTrip[i] | partnerTrip[i] | (latch_r[i] & ~relLatch[i]);
            errNxt[i]      = ownTrip[i] | (channelErrorFlag_r[i] & ~latchClearBit_r[i]);
            onNxt[i]       = reqOn[i] & ~latchNxt[i];
            // off counter restarts on every switch-off
            offNxt[i]      = chanOn[i] ? 11'h000
                           : (offCnt_r[i] == TWO_SYNC) ? TWO_SYNC : offCnt_r[i] + 11'h001;
            inrushNxt[i]   = (!chanOn[i] && offCnt_r[i] == TWO_SYNC) ? 11'h000
                           : (chanOn[i] && inrush_r[i] != INRUSH) ? inrush_r[i] + 11'h001
                           : inrush_r[i];
            initNxt[i]     = inrushNxt[i] != INRUSH;
        end
    end

    // channel state registers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_r            <= 8'h00;
            channelErrorFlag_r <= 8'h00;
            chanOn             <= 8'h00;
            initThrActive      <= 8'hff;
            for (int i = 0; i < 8; i++)
            begin
                filt_r[i]   <= 11'h000;
                offCnt_r[i] <= 11'h000;
                inrush_r[i] <= 11'h000;
            end
        end
        else
        begin
            latch_r            <= latchNxt;
            channelErrorFlag_r <= errNxt;
            chanOn             <= onNxt;
            initThrActive      <= initNxt;
            for (int i = 0; i < 8; i++)
            begin
                filt_r[i]   <= filtNxt[i];
                offCnt_r[i] <= offNxt[i];
                inrush_r[i] <= inrushNxt[i];
            end
        end
    end

    // clear bits hold for one cycle, the cycle that releases the latch
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            latchClearBit_r <= 8'h00;
        else
            latchClearBit_r <= clrWrite;
    end

    // the threshold set select drives both analog levels
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            overcurrentLevelSelect <= 1'b0;
        else
            overcurrentLevelSelect <= ctrl_r[`CTRL_OCSEL_BIT];
    end

    // ------------------------------------------------------------
    // fallback restart timers for channels 2 and 3
    // ------------------------------------------------------------
    rtime_t rtimer_r [2];
    retry_t retries_r[2];
    cnt_t   inLow_r  [2];
    rtime_t interval [2];
    logic   timerRst [2];

    // interval doubles every eight retries, capped at eight times base
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            interval[k]    = (retries_r[k] >= RSAT) ? (BASE << 3)
                                                    : (BASE << retries_r[k][4:3]);
            timerRst[k]    = inLow_r[k] == TWO_SYNC;
            autoRestart[k] = fbS && latch_r[k + 2] && inS[k]
                           && rtimer_r[k] == interval[k] - 22'h000001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int k = 0; k < 2; k++)
            begin
                rtimer_r[k]  <= 22'h000000;
                retries_r[k] <= 5'h00;
                inLow_r[k]   <= 11'h000;
            end
        end
        else
        begin
            for (int k = 0; k < 2; k++)
            begin
                // low time counter restarts on every falling input
                inLow_r[k]   <= inS[k] ? 11'h000
                              : timerRst[k] ? TWO_SYNC : inLow_r[k] + 11'h001;
                rtimer_r[k]  <= (fbS && latch_r[k + 2] && inS[k] && !autoRestart[k])
                              ? rtimer_r[k] + 22'h000001 : 22'h000000;
                retries_r[k] <= timerRst[k] ? 5'h00
                              : (autoRestart[k] && retries_r[k] != RSAT)
                              ? retries_r[k] + 5'h01 : retries_r[k];
            end
        end
    end

    // ------------------------------------------------------------
    // supply and temperature flags
    // ------------------------------------------------------------
    // set wins when recovery read and a new dip coincide
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loadSupplyUndervoltageFlag_r <= 1'b0;
            temperatureWarningBit_r      <= 1'b0;
        end
        else
        begin
            if (uvS)
                loadSupplyUndervoltageFlag_r <= 1'b1;
            else if (rdStatus && okS)
                loadSupplyUndervoltageFlag_r <= 1'b0;
            if (hotS)
                temperatureWarningBit_r <= 1'b1;
            else if (coolS)
                temperatureWarningBit_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_partnerTrips;
        pairBit[0] && ownTrip[2];
    endsequence
    property p_pairShut;
        @(posedge clk_sys) disable iff (!rst_b) s_partnerTrips |=> !chanOn[0] && latch_r[0];
    endproperty
    a_pairShut: assert property (p_pairShut) else $error("paired partner stayed on");
    property p_unpaired;
        @(posedge clk_sys) disable iff (!rst_b)
        !pairBit[0] && ownTrip[2] && !ownTrip[0] && !latch_r[0] && !latchClearBit_r[0]
        |=> !latch_r[0] && $stable(channelErrorFlag_r[0]);
    endproperty
    a_unpaired: assert property (p_unpaired) else $error("unpaired fault spread");
    property p_uvSet;
        @(posedge clk_sys) disable iff (!rst_b) uvS |=> loadSupplyUndervoltageFlag_r;
    endproperty
    a_uvSet: assert property (p_uvSet) else $error("undervoltage flag not set");
    property p_uvHold;
        @(posedge clk_sys) disable iff (!rst_b)
        loadSupplyUndervoltageFlag_r && !rdStatus |=> loadSupplyUndervoltageFlag_r;
    endproperty
    a_uvHold: assert property (p_uvHold) else $error("undervoltage flag cleared early");
    property p_ocLatch;
        @(posedge clk_sys) disable iff (!rst_b)
        chanOn[1] && overNow[1] && filt_r[1] == FILTER_M1
        |=> latch_r[1] && channelErrorFlag_r[1] && !chanOn[1];
    endproperty
    a_ocLatch: assert property (p_ocLatch) else $error("overcurrent did not latch");
    property p_latchHold;
        @(posedge clk_sys) disable iff (!rst_b)
        latch_r[5] && !latchClearBit_r[5] |=> latch_r[5] ##0 !chanOn[5];
    endproperty
    a_latchHold: assert property (p_latchHold) else $error("latch released unasked");
    property p_otLatch;
        @(posedge clk_sys) disable iff (!rst_b) otS[4] |=> latch_r[4] && channelErrorFlag_r[4];
    endproperty
    a_otLatch: assert property (p_otLatch) else $error("overtemperature did not latch");
    property p_warn;
        @(posedge clk_sys) disable iff (!rst_b)
        hotS |=> temperatureWarningBit_r ##1 (temperatureWarningBit_r || !hotS);
    endproperty
    a_warn: assert property (p_warn) else $error("warning bit not set");
    property p_warnClr;
        @(posedge clk_sys) disable iff (!rst_b) coolS && !hotS |=> !temperatureWarningBit_r;
    endproperty
    a_warnClr: assert property (p_warnClr) else $error("warning bit stuck");
    property p_fbLock;
        @(posedge clk_sys) disable iff (!rst_b) fbS && xferDone && pwrite |=> $stable(ctrl_r);
    endproperty
    a_fbLock: assert property (p_fbLock) else $error("write took effect in fallback");
    property p_rearm;
        @(posedge clk_sys) disable iff (!rst_b)
        !chanOn[6] && offCnt_r[6] == TWO_SYNC |=> initThrActive[6];
    endproperty
    a_rearm: assert property (p_rearm) else $error("initial threshold not rearmed");
    property p_timerRst;
        @(posedge clk_sys) disable iff (!rst_b) timerRst[0] |=> retries_r[0] == 5'h00;
    endproperty
    a_timerRst: assert property (p_timerRst) else $error("restart timer not reset");
    property p_fbOnly;
        @(posedge clk_sys) disable iff (!rst_b) fbS |=> !chanOn[0] || !$past(fbS);
    endproperty
    a_fbOnly: assert property (p_fbOnly) else $error("channel 0 driven in fallback");
endmodule // channel_fault_latch_protection

`default_nettype wire

// ==== verif/apb_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// apb master standing in for the controller
// ----------------------------------------------------------------
module apb_master_model (
    input  wire logic        clk_sys,   // system clock
    output logic             psel,      // select
    output logic             penable,   // access phase
    output logic             pwrite,    // direction
    output logic [11:0]      paddr,     // byte address
    output logic [31:0]      pwdata,    // write data
    input  wire logic [31:0] prdata,    // read data
    input  wire logic        pready,    // ready
    input  wire logic        pslverr    // error
);
    // idle bus from time zero so the slave never sees an unknown select
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // no wait count assumed: only the bench watchdog ends a hung access
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // address and data lines show the inverse so stale data never looks valid
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // apb_master_model

`default_nettype wire

// ==== verif/channel_fault_latch_protection_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "channel_fault_defines.svh"

module channel_fault_latch_protection_test;
    import channel_fault_pkg::*;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, se, ocSel;
    logic        fallbackMode, supplyUv, supplyOk, dieHot, dieCool;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  inPin;
    chan_mask_t  overInit, overSteady, overTemp, chanOn, initThr;
    int          err_count, cmp_count;

    apb_master_model u_apb_master_model (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // short restart base keeps the fallback retry inside the run
    channel_fault_latch_protection #(.RESTART_BASE_CYC(20)) u_channel_fault_latch_protection (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .overInit(overInit), .overSteady(overSteady), .overTemp(overTemp), .inPin(inPin),
        .fallbackMode(fallbackMode), .supplyUv(supplyUv), .supplyOk(supplyOk),
        .dieHot(dieHot), .dieCool(dieCool), .chanOn(chanOn), .initThrActive(initThr),
        .overcurrentLevelSelect(ocSel));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_apb_master_model.xfer(1'b1, a, d, rd, se);
    endtask
    task automatic rdr(input logic [11:0] a);
        u_apb_master_model.xfer(1'b0, a, 32'h0, rd, se);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_unmapped;
        chk("init", 32'hff, {24'h0, initThr});
        wr(12'h010, 32'hffff_ffff);
        chk("slverr", 32'h1, {31'h0, se});
        rdr(`ADDR_CTRL);
        chk("ctrl", 32'h0, rd);
    endtask
    task automatic t_pair_trip;
        wr(`ADDR_CTRL, 32'h0000_1107);
        cyc(2);
        chk("on", 32'h07, {24'h0, chanOn});
        chk("ocsel", 32'h1, {31'h0, ocSel});
        overInit <= 8'h01;
        cyc(115);
        chk("on", 32'h02, {24'h0, chanOn});
        rdr(`ADDR_STATUS);
        chk("err", 32'h01, {24'h0, rd[7:0]});
        overInit <= 8'h00;
        cyc(8);
        wr(`ADDR_CLEAR, 32'h0000_0005);
        cyc(2);
        chk("on", 32'h07, {24'h0, chanOn});
        rdr(`ADDR_CLEAR);
        chk("clr", 32'h0, rd);
    endtask
    task automatic t_inrush;
        chk("thr", 32'h1, {31'h0, initThr[1]});
        cyc(1300);
        chk("thr", 32'h0, {31'h0, initThr[1]});
        // above the initial level only: the steady level must not trip
        overInit <= 8'h02;
        cyc(110);
        chk("on", 32'h1, {31'h0, chanOn[1]});
        overInit <= 8'h00;
        wr(`ADDR_CTRL, 32'h0000_1105);
        cyc(60);
        chk("thr", 32'h1, {31'h0, initThr[1]});
    endtask
    task automatic t_uv_warn;
        supplyUv <= 1'b1;
        dieHot   <= 1'b1;
        cyc(8);
        rdr(`ADDR_STATUS);
        chk("uv", 32'h1, {31'h0, rd[8]});
        rdr(`ADDR_CFG2);
        chk("warn", 32'h1, rd);
        chk("on", 32'h05, {24'h0, chanOn});
        supplyUv <= 1'b0;
        supplyOk <= 1'b1;
        dieHot   <= 1'b0;
        dieCool  <= 1'b1;
        cyc(8);
        rdr(`ADDR_STATUS);
        chk("uv", 32'h1, {31'h0, rd[8]});
        rdr(`ADDR_STATUS);
        chk("uv", 32'h0, {31'h0, rd[8]});
        rdr(`ADDR_CFG2);
        chk("warn", 32'h0, rd);
    endtask
    task automatic t_unpaired;
        wr(`ADDR_CTRL, 32'h0000_1025);
        overTemp <= 8'h24;
        cyc(8);
        chk("on", 32'h01, {24'h0, chanOn});
        overTemp <= 8'h00;
        cyc(8);
        chk("on", 32'h01, {24'h0, chanOn});
        rdr(`ADDR_STATUS);
        chk("err", 32'h24, {24'h0, rd[7:0]});
        wr(`ADDR_CLEAR, 32'h0000_0024);
        cyc(2);
        chk("on", 32'h25, {24'h0, chanOn});
        wr(`ADDR_CTRL, 32'h0000_1105);
    endtask
    task automatic t_fallback;
        fallbackMode <= 1'b1;
        inPin        <= 2'b01;
        cyc(8);
        chk("on", 32'h04, {24'h0, chanOn});
        wr(`ADDR_CTRL, 32'h0);
        rdr(`ADDR_CTRL);
        chk("ctrl", 32'h1105, rd);
        rdr(`ADDR_STATUS);
        chk("mode", 32'h1, {31'h0, rd[9]});
        overTemp <= 8'h04;
        cyc(8);
        chk("on", 32'h00, {24'h0, chanOn});
        overTemp <= 8'h00;
        cyc(40);
        chk("on", 32'h04, {24'h0, chanOn});
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // watchdog sized well past the roughly 1770 cycles of the sequence
    initial
    begin
        cyc(5000);
        err_count++;
        report_and_stop;
    end
    initial
    begin
        {rst_b, fallbackMode, supplyUv, supplyOk, dieHot} = '0;
        {dieCool, inPin, overInit, overSteady, overTemp} = '0;
        err_count = 0;
        cmp_count = 0;
        cyc(2);
        rst_b <= 1'b1;
        t_unmapped;
        t_pair_trip;
        t_inrush;
        t_uv_warn;
        t_unpaired;
        t_fallback;
        report_and_stop;
    end
endmodule // channel_fault_latch_protection_test

`default_nettype wire
